// ===== core/dam_regs.svh
// Purpose: constants of the DS3 receive alarm monitor
// Assumes: 100 MHz core clock
// Notes: counts derived from times in the expressions below
`ifndef DAM_REGS_SVH
`define DAM_REGS_SVH
`define DAM_CLK_HZ 100000000
`define DAM_SEC_S 1
`define DAM_SEC_CYC (`DAM_SEC_S * `DAM_CLK_HZ)
`define DAM_BLK_BITS 85
`define DAM_BLKS 8
`define DAM_SUBS 7
`define DAM_F_PAT 4'h9
`define DAM_M_PAT 3'h2
`define DAM_F_LOST 1020
`define DAM_LOP_WIN 1024
`define DAM_LOP_ERRS 240
`define DAM_LOP_CLR 64
`define DAM_LOS_ZEROS 128
`define DAM_EXZ_ZEROS 3
`define DAM_FID_ZEROS 16
`define DAM_BPV_LIMIT 44
`define DAM_PERSIST_SECS 3
`define DAM_ALARMS 9
`endif

// ===== core/dam_pkg.sv
// Purpose: types of the DS3 receive alarm monitor
// Assumes: nothing
// Notes: alarm struct bit 0 is ais
package dam_pkg;
    typedef struct packed {
        logic valid;
        logic pos;
        logic neg;
    } dam_line_t;
    typedef struct packed {
        logic [6:0][2:0] cbit;
        logic [1:0] xbit;
        logic [1:0] pbit;
    } dam_ovh_t;
    typedef struct packed {
        logic bpv_err;
        logic line_violation_alarm;
        logic format_mismatch_alarm;
        logic blue;
        logic out_of_frame;
        logic signal_lost;
        logic pattern_sync_lost;
        logic idle;
        logic ais;
    } dam_alarm_t;
endpackage

// ===== core/dam_persist.sv
// Purpose: whole-second set and clear persistence
// Assumes: sec_tick one cycle per second
// Notes: a second neither good nor bad restarts both runs
`timescale 1ns/1ps
module dam_persist #(
    parameter int SET_SECS = 3,
    parameter int CLR_SECS = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sec_tick,
    input wire logic set_sec,
    input wire logic clr_sec,
    output logic alarm_r
);
    logic [2:0] set_run_r;
    logic [2:0] clr_run_r;

    // Consecutive second runs, saturating
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            set_run_r <= 3'h0;
            clr_run_r <= 3'h0;
            alarm_r <= 1'b0;
        end
        else if (sec_tick)
        begin
            if (set_sec)
            begin
                clr_run_r <= 3'h0;
                if (set_run_r != 3'h7)
                    set_run_r <= set_run_r + 3'h1;
                if (32'(set_run_r) + 1 >= SET_SECS)
                    alarm_r <= 1'b1;
            end
            else if (clr_sec)
            begin
                set_run_r <= 3'h0;
                if (clr_run_r != 3'h7)
                    clr_run_r <= clr_run_r + 3'h1;
                if (32'(clr_run_r) + 1 >= CLR_SECS)
                    alarm_r <= 1'b0;
            end
            else
            begin
                set_run_r <= 3'h0;
                clr_run_r <= 3'h0;
            end
        end
    end
endmodule // dam_persist

// ===== core/dam_alarm_log.sv
// Purpose: alarm-second counter and sticky history for one alarm
// Assumes: sec_tick one cycle per second
// Notes: cleared by test_start only
`timescale 1ns/1ps
module dam_alarm_log #(
    parameter int CW = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sec_tick,
    input wire logic test_start,
    input wire logic live,
    output logic [CW-1:0] secs_r,
    output logic hist_r
);
    logic seen_r;

    // Occurred at least once in the current second
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            seen_r <= 1'b0;
        else if (sec_tick || test_start)
            seen_r <= 1'b0;
        else if (live)
            seen_r <= 1'b1;
    end

    // Saturating, so a long test never wraps to zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            secs_r <= '0;
        else if (test_start)
            secs_r <= '0;
        else if (sec_tick && (seen_r || live) && secs_r != '1)
            secs_r <= secs_r + 1'b1;
    end

    // Sticky; a live alarm wins over the clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hist_r <= 1'b0;
        else if (live)
            hist_r <= 1'b1;
        else if (test_start)
            hist_r <= 1'b0;
    end
endmodule // dam_alarm_log

// ===== core/dam_top.sv
// Purpose: DS3 receive framing, overhead capture and alarm monitor
// Assumes: one line_in.valid strobe per received pulse position
// Notes: B3ZS substitutions are not removed before BPV counting
// Notes on behaviour
// - Present every received C-bit, grouped by overhead row.
// - Row one third C-bit is the far-end alarm channel bit.
// - Rows two, five, six, seven C-bits form data links, selectable.
// - Present received X-bits and P-bits.
// - AIS: 1010 payload, framed, C-bits zero, three whole seconds.
// - Blue: 1010 payload, framed, any C-bits, three whole seconds.
// - Idle: 1100 payload, framed, parity good, row3 C zero, X ones.
// - Pattern sync lost at 240 errors within 1024 payload bits.
// - Pattern sync regained after 64 error-free payload bits.
// - Signal lost after 128 empty positions, back on any pulse.
// - Out of frame when F-sync or M-sync is missing.
// - F-sync lost when fully errored F bursts exceed 1020.
// - M-sync lost when two of three M triples are not 010.
// - Format mismatch, no AIS or OOF, three seconds declares.
// - Format mismatch clears after three seconds without it.
// - Violation alarm after three seconds of loss or over 44 BPVs.
// - Violation alarm clears after three clean seconds below 44.
// - Per-alarm counters of seconds holding the alarm.
// - Live and sticky history flag for each alarm.
// - Zero-run flag on three or more consecutive empty positions.
// - Report recovered line clock frequency in hertz.
// - Count seconds holding at least one bipolar violation.
`timescale 1ns/1ps
`include "dam_regs.svh"
module dam_top #(
    parameter int SEC_CYC = `DAM_SEC_CYC,
    parameter int CW = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input dam_pkg::dam_line_t line_in,
    input wire logic test_start,
    input wire logic cfg_cbit,
    input wire logic [3:0] dl_sel,
    output dam_pkg::dam_ovh_t ovh_r,
    output logic feac_bit_r,
    output logic [11:0] dl_bits_r,
    output logic dl_valid_r,
    output logic fmt_m13_r,
    output dam_pkg::dam_alarm_t alarm_live_r,
    output dam_pkg::dam_alarm_t alarm_hist_r,
    output logic [`DAM_ALARMS-1:0][CW-1:0] alarm_secs_r,
    output logic zero_run_flag_r,
    output logic [31:0] rx_hz_r
);
    import dam_pkg::*;
    localparam int QTR = SEC_CYC / 4;

    logic [6:0] blk_bit_r;
    logic [2:0] blk_r, sub_r, f_err_cnt_r, m_acc_r, m_hist_r;
    logic [10:0] burst_r;
    logic f_sync_r, m_sync_r, m_slip_r;
    logic strobe, pulse, ovh, fbit, cbit, mxp, pay, f_err, slip;
    logic sub_end, frame_end, m_err;
    logic [1:0] cidx;
    logic [6:0] pidx;
    dam_ovh_t ovh_b_r;
    logic pat1010_r, pat1100_r, par_r, par_prev_r;
    logic pat1010_nxt, pat1100_nxt, par_nxt;
    logic ais_frm_r, blue_frm_r, idle_frm_r;
    logic [4:0] fid_cnt_r;
    logic [31:0] tb_r, bits_sec_r;
    logic [1:0] qtr_r;
    logic q_tick, sec_tick;
    logic [7:0] zr_cnt_r, bpv_sec_r;
    logic los_r, last_pos_r, bpv;
    logic [14:0] prbs_r;
    logic [9:0] win_r;
    logic [7:0] lop_err_r;
    logic [6:0] lop_run_r;
    logic lop_r, prbs_err;
    logic oof, ais_cond, blue_cond, ffm_cond, los_sec_r;
    logic [2:0] hold_r, held;
    logic ffm_any_r;
    logic ais_a, blue_a, ffm_a, lcv_a;
    dam_alarm_t live;

    function automatic logic [2:0] sub_add(input logic [2:0] s,
                                           input logic [2:0] inc);
        logic [3:0] t;
        t = {1'b0, s} + {1'b0, inc};
        return (t >= 4'(`DAM_SUBS)) ? 3'(t - 4'(`DAM_SUBS)) : t[2:0];
    endfunction

    function automatic logic [1:0] pop3(input logic [2:0] v);
        return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    endfunction

    // Position decode inside the M-frame
    assign strobe = line_in.valid;
    assign pulse = line_in.pos | line_in.neg;
    assign ovh = (blk_bit_r == 7'h0);
    assign fbit = ovh & blk_r[0];
    assign cbit = ovh & ~blk_r[0] & (blk_r != 3'h0);
    assign mxp = ovh & (blk_r == 3'h0);
    assign pay = strobe & ~ovh;
    assign cidx = blk_r[2:1] - 2'h1;
    assign pidx = blk_bit_r - 7'h1;
    assign f_err = strobe & fbit & (pulse != 1'(`DAM_F_PAT >> blk_r[2:1]));
    assign slip = ~f_sync_r & f_err;
    assign sub_end = strobe & ~slip & (blk_bit_r == 7'(`DAM_BLK_BITS - 1))
                     & (blk_r == 3'(`DAM_BLKS - 1));
    assign frame_end = sub_end & (sub_r == 3'(`DAM_SUBS - 1));
    assign m_err = pulse != 1'(`DAM_M_PAT >> (3'h6 - sub_r));

    // Bit, block and subframe counters; slips hold one position
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            blk_bit_r <= 7'h0;
            blk_r <= 3'h0;
            sub_r <= 3'h0;
        end
        else if (strobe && !slip)
        begin
            if (blk_bit_r == 7'(`DAM_BLK_BITS - 1))
            begin
                blk_bit_r <= 7'h0;
                blk_r <= blk_r + 3'h1;
                if (sub_end)
                    sub_r <= sub_add(sub_r, m_slip_r ? 3'h2 : 3'h1);
            end
            else
                blk_bit_r <= blk_bit_r + 7'h1;
        end
    end

    // F-sync: a burst is the four F bits of one subframe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            f_err_cnt_r <= 3'h0;
            burst_r <= 11'h0;
            f_sync_r <= 1'b0;
        end
        else if (strobe && fbit)
        begin
            if (slip)
                f_err_cnt_r <= 3'h0;
            else if (blk_r == 3'h7)
            begin
                f_err_cnt_r <= 3'h0;
                if (!f_sync_r)
                    f_sync_r <= (f_err_cnt_r == 3'h0);
                else if (f_err_cnt_r + 3'(f_err) == 3'h4)
                begin
                    if (burst_r >= 11'(`DAM_F_LOST))
                    begin
                        f_sync_r <= 1'b0;
                        burst_r <= 11'h0;
                    end
                    else
                        burst_r <= burst_r + 11'h1;
                end
                else
                    burst_r <= 11'h0;
            end
            else
                f_err_cnt_r <= f_err_cnt_r + 3'(f_err);
        end
    end

    // M-sync over the last three M triples; a loss skips a subframe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            m_acc_r <= 3'h0;
            m_hist_r <= 3'h7;
            m_sync_r <= 1'b0;
            m_slip_r <= 1'b0;
        end
        else if (strobe && mxp && sub_r >= 3'h4 && f_sync_r)
        begin
            if (sub_r == 3'h6)
            begin
                m_acc_r <= 3'h0;
                m_hist_r <= {m_hist_r[1:0], (m_acc_r != 3'h0) | m_err};
                m_sync_r <= pop3({m_hist_r[1:0],
                                  (m_acc_r != 3'h0) | m_err}) < 2'h2;
                m_slip_r <= ~m_sync_r & ((m_acc_r != 3'h0) | m_err);
            end
            else
                m_acc_r <= m_acc_r | {2'h0, m_err};
        end
        else if (sub_end)
            m_slip_r <= 1'b0;
    end

    // Overhead capture, latched whole at the end of the M-frame
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ovh_b_r <= '0;
        else if (strobe && cbit)
            ovh_b_r.cbit[sub_r][cidx] <= pulse;
        else if (strobe && mxp && sub_r < 3'h2)
            ovh_b_r.xbit[sub_r[0]] <= pulse;
        else if (strobe && mxp && sub_r < 3'h4)
            ovh_b_r.pbit[sub_r[0]] <= pulse;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ovh_r <= '0;
            feac_bit_r <= 1'b0;
            dl_bits_r <= 12'h0;
            dl_valid_r <= 1'b0;
        end
        else
        begin
            dl_valid_r <= frame_end;
            if (frame_end)
            begin
                ovh_r <= ovh_b_r;
                feac_bit_r <= ovh_b_r.cbit[0][2];
                dl_bits_r <= {ovh_b_r.cbit[6] & {3{dl_sel[3]}},
                              ovh_b_r.cbit[5] & {3{dl_sel[2]}},
                              ovh_b_r.cbit[4] & {3{dl_sel[1]}},
                              ovh_b_r.cbit[1] & {3{dl_sel[0]}}};
            end
        end
    end

    // Payload patterns and parity over one M-frame
    assign pat1010_nxt = pat1010_r & ~(pay & (pulse == pidx[0]));
    assign pat1100_nxt = pat1100_r & ~(pay & (pulse == pidx[1]));
    assign par_nxt = par_r ^ (pay & pulse);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pat1010_r <= 1'b1;
            pat1100_r <= 1'b1;
            par_r <= 1'b0;
            par_prev_r <= 1'b0;
            ais_frm_r <= 1'b0;
            blue_frm_r <= 1'b0;
            idle_frm_r <= 1'b0;
        end
        else if (frame_end)
        begin
            pat1010_r <= 1'b1;
            pat1100_r <= 1'b1;
            par_r <= 1'b0;
            par_prev_r <= par_nxt;
            ais_frm_r <= pat1010_nxt & (ovh_b_r.cbit == '0);
            blue_frm_r <= pat1010_nxt;
            idle_frm_r <= pat1100_nxt & (ovh_b_r.cbit[2] == 3'h0)
                          & (ovh_b_r.xbit == 2'h3)
                          & (ovh_b_r.pbit == {2{par_prev_r}});
        end
        else
        begin
            pat1010_r <= pat1010_nxt;
            pat1100_r <= pat1100_nxt;
            par_r <= par_nxt;
            if (los_r || oof)
            begin
                ais_frm_r <= 1'b0;
                blue_frm_r <= 1'b0;
                idle_frm_r <= 1'b0;
            end
        end
    end

    // Quarter and whole seconds from the core clock only
    assign q_tick = (tb_r == 32'(QTR - 1));
    assign sec_tick = q_tick & (qtr_r == 2'h3);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tb_r <= 32'h0;
            qtr_r <= 2'h0;
        end
        else if (q_tick)
        begin
            tb_r <= 32'h0;
            qtr_r <= qtr_r + 2'h1;
        end
        else
            tb_r <= tb_r + 32'h1;
    end

    // Format from row-one first C-bit zeros per quarter second
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fid_cnt_r <= 5'h0;
            fmt_m13_r <= 1'b0;
        end
        else if (q_tick)
        begin
            fid_cnt_r <= 5'h0;
            fmt_m13_r <= fid_cnt_r >= 5'(`DAM_FID_ZEROS);
        end
        else if (strobe && cbit && sub_r == 3'h0 && blk_r == 3'h2
                 && !pulse && fid_cnt_r != 5'h1f)
            fid_cnt_r <= fid_cnt_r + 5'h1;
    end

    // Empty-position run: signal loss and zero-run flag
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            zr_cnt_r <= 8'h0;
            los_r <= 1'b0;
            zero_run_flag_r <= 1'b0;
        end
        else if (strobe && pulse)
        begin
            zr_cnt_r <= 8'h0;
            los_r <= 1'b0;
            zero_run_flag_r <= 1'b0;
        end
        else if (strobe)
        begin
            if (zr_cnt_r != 8'hff)
                zr_cnt_r <= zr_cnt_r + 8'h1;
            if (zr_cnt_r >= 8'(`DAM_LOS_ZEROS - 1))
                los_r <= 1'b1;
            if (zr_cnt_r >= 8'(`DAM_EXZ_ZEROS - 1))
                zero_run_flag_r <= 1'b1;
        end
    end

    // Bipolar violation: two pulses of the same polarity in a row
    assign bpv = strobe & pulse & (line_in.pos == last_pos_r);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            last_pos_r <= 1'b0;
        else if (strobe && pulse)
            last_pos_r <= line_in.pos;
    end

    // Self-synchronising PRBS15 checker on payload bits
    assign prbs_err = pulse ^ prbs_r[14] ^ prbs_r[13];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prbs_r <= 15'h0;
            win_r <= 10'h0;
            lop_err_r <= 8'h0;
            lop_run_r <= 7'h0;
            lop_r <= 1'b1;
        end
        else if (pay)
        begin
            prbs_r <= {prbs_r[13:0], pulse};
            win_r <= win_r + 10'h1; // Wraps at 1024 bits
            if (win_r == 10'(`DAM_LOP_WIN - 1))
                lop_err_r <= 8'h0;
            else if (prbs_err && lop_err_r != 8'hff)
                lop_err_r <= lop_err_r + 8'h1;
            if (prbs_err)
            begin
                lop_run_r <= 7'h0;
                if (lop_err_r >= 8'(`DAM_LOP_ERRS - 1))
                    lop_r <= 1'b1;
            end
            else if (lop_run_r >= 7'(`DAM_LOP_CLR - 1))
                lop_r <= 1'b0;
            else
                lop_run_r <= lop_run_r + 7'h1;
        end
    end

    // Conditions that must hold through a whole second
    assign oof = ~f_sync_r | ~m_sync_r;
    assign ais_cond = ais_frm_r & ~oof & ~los_r;
    assign blue_cond = blue_frm_r & ~oof & ~los_r;
    assign ffm_cond = (fmt_m13_r == cfg_cbit) & ~ais_a & ~oof;
    assign held = hold_r & {ffm_cond, blue_cond, ais_cond};

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hold_r <= 3'h7;
            ffm_any_r <= 1'b0;
            los_sec_r <= 1'b0;
            bpv_sec_r <= 8'h0;
            bits_sec_r <= 32'h0;
            rx_hz_r <= 32'h0;
        end
        else if (sec_tick)
        begin
            hold_r <= 3'h7;
            ffm_any_r <= 1'b0;
            los_sec_r <= 1'b0;
            bpv_sec_r <= 8'h0;
            bits_sec_r <= 32'h0;
            rx_hz_r <= bits_sec_r + 32'(strobe);
        end
        else
        begin
            hold_r <= held;
            ffm_any_r <= ffm_any_r | ffm_cond;
            los_sec_r <= los_sec_r | los_r;
            if (bpv && bpv_sec_r != 8'hff)
                bpv_sec_r <= bpv_sec_r + 8'h1;
            bits_sec_r <= bits_sec_r + 32'(strobe);
        end
    end

    // Persistence: AIS and blue clear after one clean second
    dam_persist #(.SET_SECS(`DAM_PERSIST_SECS), .CLR_SECS(1)) u_ais (
        .core_clk(core_clk), .rst(rst), .sec_tick(sec_tick),
        .set_sec(held[0]), .clr_sec(~held[0]), .alarm_r(ais_a));
    dam_persist #(.SET_SECS(`DAM_PERSIST_SECS), .CLR_SECS(1)) u_blue (
        .core_clk(core_clk), .rst(rst), .sec_tick(sec_tick),
        .set_sec(held[1]), .clr_sec(~held[1]), .alarm_r(blue_a));
    dam_persist #(.SET_SECS(`DAM_PERSIST_SECS),
                  .CLR_SECS(`DAM_PERSIST_SECS)) u_ffm (
        .core_clk(core_clk), .rst(rst), .sec_tick(sec_tick),
        .set_sec(held[2]),
        .clr_sec(~(ffm_any_r | ffm_cond)), .alarm_r(ffm_a));
    dam_persist #(.SET_SECS(`DAM_PERSIST_SECS),
                  .CLR_SECS(`DAM_PERSIST_SECS)) u_lcv (
        .core_clk(core_clk), .rst(rst), .sec_tick(sec_tick),
        .set_sec(los_sec_r | los_r
                 | (bpv_sec_r > 8'(`DAM_BPV_LIMIT))),
        .clr_sec(~los_sec_r & ~los_r
                 & (bpv_sec_r < 8'(`DAM_BPV_LIMIT))),
        .alarm_r(lcv_a));

    // Live alarm levels
    always_comb
    begin
        live.ais = ais_a;
        live.idle = idle_frm_r & ~oof & ~los_r;
        live.pattern_sync_lost = lop_r;
        live.signal_lost = los_r;
        live.out_of_frame = oof;
        live.blue = blue_a;
        live.format_mismatch_alarm = ffm_a;
        live.line_violation_alarm = lcv_a;
        live.bpv_err = bpv;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            alarm_live_r <= '0;
        else
            alarm_live_r <= live;
    end

    // One second counter and history flag per alarm
    for (genvar i = 0; i < `DAM_ALARMS; i++)
    begin : g_log
        dam_alarm_log #(.CW(CW)) u_log (
            .core_clk(core_clk),
            .rst(rst),
            .sec_tick(sec_tick),
            .test_start(test_start),
            .live(live[i]),
            .secs_r(alarm_secs_r[i]),
            .hist_r(alarm_hist_r[i]));
    end
endmodule // dam_top

// ===== bench/dam_checker.sv
// Purpose: port assertions for the DS3 receive alarm monitor
// Assumes: dl_sel held steady by the bench
// Notes: bound to dam_top at the foot of this file
`timescale 1ns/1ps
module dam_checker
    import dam_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input dam_pkg::dam_line_t line_in,
    input wire logic test_start,
    input wire logic [3:0] dl_sel,
    input dam_pkg::dam_ovh_t ovh_r,
    input wire logic feac_bit_r,
    input wire logic [11:0] dl_bits_r,
    input wire logic dl_valid_r,
    input dam_pkg::dam_alarm_t alarm_live_r,
    input dam_pkg::dam_alarm_t alarm_hist_r,
    input wire logic [8:0][CW-1:0] alarm_secs_r,
    input wire logic zero_run_flag_r
);
    logic [7:0] empty_r;
    // Run of empty positions; saturates so it never wraps to 127 again
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            empty_r <= 8'h00;
        else if (line_in.valid)
            empty_r <= (line_in.pos | line_in.neg) ? 8'h00 :
                (empty_r == 8'hff ? 8'hff : empty_r + 8'h01);
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_feac; feac_bit_r == ovh_r.cbit[0][2]; endproperty
    a_feac: assert property (p_feac) else $error("feac bit off");
    property p_dl; $stable(dl_sel) |-> dl_bits_r ==
        {ovh_r.cbit[6] & {3{dl_sel[3]}}, ovh_r.cbit[5] & {3{dl_sel[2]}},
        ovh_r.cbit[4] & {3{dl_sel[1]}}, ovh_r.cbit[1] & {3{dl_sel[0]}}};
    endproperty
    a_dl: assert property (p_dl) else $error("data link bits off");
    property p_ovh; !dl_valid_r |-> $stable(ovh_r); endproperty
    a_ovh: assert property (p_ovh) else $error("overhead moved");
    property p_dlv; dl_valid_r |=> !dl_valid_r; endproperty
    a_dlv: assert property (p_dlv) else $error("frame strobe long");
    property p_los_set; line_in.valid && !(line_in.pos || line_in.neg)
        && empty_r == 8'h7f |-> ##2 alarm_live_r.signal_lost; endproperty
    a_los_set: assert property (p_los_set) else $error("loss late");
    property p_los_clr; line_in.valid && (line_in.pos || line_in.neg)
        |-> ##3 !alarm_live_r.signal_lost; endproperty
    a_los_clr: assert property (p_los_clr) else $error("loss held");
    property p_zero; line_in.valid && (line_in.pos || line_in.neg)
        |-> ##[2:3] !zero_run_flag_r; endproperty
    a_zero: assert property (p_zero) else $error("zero run held");
    property p_hist; alarm_live_r.signal_lost |-> alarm_hist_r.signal_lost;
    endproperty
    a_hist: assert property (p_hist) else $error("history missing");
    property p_sticky; !test_start && !$past(test_start) |=>
        (alarm_hist_r & $past(alarm_hist_r)) == $past(alarm_hist_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("history lost");
    property p_secs; !test_start && !$past(test_start) |=>
        CW'(alarm_secs_r[3] - $past(alarm_secs_r[3])) <= CW'(1); endproperty
    a_secs: assert property (p_secs) else $error("second count jump");
    c_loss: cover property ($rose(alarm_live_r.signal_lost));
    c_bpv: cover property (alarm_live_r.bpv_err);
    c_lcv: cover property ($fell(alarm_live_r.line_violation_alarm));
endmodule // dam_checker
bind dam_top dam_checker #(.CW(CW)) u_chk (.core_clk, .rst, .line_in,
    .test_start, .dl_sel, .ovh_r, .feac_bit_r, .dl_bits_r, .dl_valid_r,
    .alarm_live_r, .alarm_hist_r, .alarm_secs_r, .zero_run_flag_r);

// ===== bench/dam_line_tx.sv
// Purpose: DS3 line transmitter model feeding received pulse positions
// Assumes: controls change just after the falling edge
// Notes: marks alternate polarity unless a violation is asked for
`timescale 1ns/1ps
module dam_line_tx
    import dam_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic mark,
    input wire logic hold_pol,
    output dam_pkg::dam_line_t line_in
);
    logic pol_r;
    // Holding polarity makes the following mark a bipolar violation
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pol_r <= 1'b1;
        else if (en && mark && !hold_pol)
            pol_r <= !pol_r;
    end
    // Empty positions and idle gaps carry no pulse at all
    assign line_in = '{en, en & mark & pol_r, en & mark & ~pol_r};
endmodule // dam_line_tx

// ===== bench/tb.sv
// Purpose: self-checking bench for the DS3 receive alarm monitor
// Assumes: a second shortened to 400 core cycles
// Notes: framing is never reached; line alarms are exercised
`timescale 1ns/1ps
module tb;
    import dam_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic mk = 1'b0;
    logic hp = 1'b0;
    logic test_start = 1'b0;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    dam_line_t line_in;
    dam_alarm_t live;
    dam_alarm_t hist;
    logic [8:0][15:0] secs;
    logic zr;
    logic [31:0] hz;
    dam_line_tx tx (.core_clk, .rst, .en, .mark(mk), .hold_pol(hp), .line_in);
    dam_top #(.SEC_CYC(400)) uut (.core_clk, .rst, .line_in, .test_start,
        .cfg_cbit(1'b1), .dl_sel(4'h5), .ovh_r(), .feac_bit_r(),
        .dl_bits_r(), .dl_valid_r(), .fmt_m13_r(), .alarm_live_r(live),
        .alarm_hist_r(hist), .alarm_secs_r(secs), .zero_run_flag_r(zr),
        .rx_hz_r(hz));
    // Clock and hang guard; the run needs about 5500 cycles
    initial
        forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            fails++;
            report_and_stop;
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobe stays up between back-to-back calls
    task automatic send(int n, logic m, logic h);
        en = 1'b1;
        mk = m;
        hp = h;
        repeat (n) @(negedge core_clk);
    endtask
    task automatic idle(int n);
        en = 1'b0;
        repeat (n) @(negedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        idle(1);
        chk("oof", live.out_of_frame, 1'b1);
        chk("hist", hist.signal_lost, 1'b0);
        send(127, 1'b0, 1'b0);
        idle(3);
        chk("los early", live.signal_lost, 1'b0);
        chk("exz", zr, 1'b1);
        send(1, 1'b0, 1'b0);
        idle(2);
        chk("los", live.signal_lost, 1'b1);
        chk("los hist", hist.signal_lost, 1'b1);
        send(1, 1'b1, 1'b0);
        idle(2);
        chk("los clr", live.signal_lost, 1'b0);
        chk("los sticky", hist.signal_lost, 1'b1);
        chk("exz clr", zr, 1'b0);
        send(2, 1'b0, 1'b0);
        idle(2);
        chk("exz two", zr, 1'b0);
        send(1, 1'b0, 1'b0);
        idle(2);
        chk("exz three", zr, 1'b1);
        test_start = 1'b1;
        idle(1);
        test_start = 1'b0;
        idle(2);
        chk("hist clr", hist.signal_lost, 1'b0);
        send(2000, 1'b0, 1'b0);
        chk("lcv", live.line_violation_alarm, 1'b1);
        chk("lop clr", live.pattern_sync_lost, 1'b0);
        chk("los secs", secs[3] >= 16'h0004, 1'b1);
        send(2400, 1'b1, 1'b0);
        chk("lcv clr", live.line_violation_alarm, 1'b0);
        chk("lop", live.pattern_sync_lost, 1'b1);
        chk("rx hz", hz, 32'h0000_0190);
        chk("no bpv", hist.bpv_err, 1'b0);
        send(1, 1'b1, 1'b1);
        send(1, 1'b1, 1'b0);
        idle(3);
        chk("bpv", hist.bpv_err, 1'b1);
        idle(900);
        chk("bpv secs", secs[8] >= 16'h0001, 1'b1);
        report_and_stop;
    end
endmodule // tb
